// ===== hdl/dpsec_defs.svh
`ifndef DPSEC_DEFS_SVH
`define DPSEC_DEFS_SVH

// clock and acquisition window timing
`define DPSEC_CLK_PERIOD_NS   10
`define DPSEC_WIN_INIT_NS     8000
`define DPSEC_WIN_EXT_NS      400000
`define DPSEC_WIN_INIT_CYC    (`DPSEC_WIN_INIT_NS / `DPSEC_CLK_PERIOD_NS)
`define DPSEC_WIN_EXT_CYC     (`DPSEC_WIN_EXT_NS / `DPSEC_CLK_PERIOD_NS)
`define DPSEC_WIN_W           16
`define DPSEC_EDGE_COUNT      4'h8

// write-once latch key and majority threshold
`define DPSEC_WOL_KEY         32'h50536f43
`define DPSEC_WOL_MIN_MATCH   6'h1c

// breakpoint comparators
`define DPSEC_NUM_PROG_CMP    6
`define DPSEC_NUM_LIT_CMP     2
`define DPSEC_NUM_CMP         (`DPSEC_NUM_PROG_CMP + `DPSEC_NUM_LIT_CMP)

// acquire key shifted in on the selected pair, value arbitrary
`define DPSEC_ACQ_KEY         32'h5a3c96e1

// flash protection level with no protection
`define DPSEC_PROT_NONE       2'h0

`endif

// ===== hdl/dpsec_pkg.sv
`include "dpsec_defs.svh"

package dpsec_pkg;

   typedef enum logic [2:0] {
      ST_INIT,
      ST_OPEN,
      ST_EXT,
      ST_ACQ,
      ST_CLOSED,
      ST_LOCKED
   } dpsec_acq_t;

   typedef enum logic [3:0] {
      OP_NOP,
      OP_HALT,
      OP_STEP,
      OP_RESUME,
      OP_MEM_RD,
      OP_MEM_WR,
      OP_BKPT_SET,
      OP_WP_SET,
      OP_WOL_WRITE,
      OP_WOL_READ,
      OP_PROT_RAISE,
      OP_FULL_ERASE,
      OP_BLOCK_OP
   } dpsec_op_t;

   typedef enum logic [1:0] {
      WP_OFF,
      WP_ADDR,
      WP_RANGE,
      WP_VALUE
   } dpsec_wp_t;

   typedef struct packed {
      logic        valid;
      dpsec_op_t   op;
      logic [2:0]  index;
      logic [1:0]  aux;
      logic [31:0] addr;
      logic [31:0] data;
   } dpsec_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        refused;
      logic [31:0] data;
   } dpsec_rsp_t;

   typedef struct packed {
      logic        halt;
      logic        step;
      logic        memReq;
      logic        memWrite;
      logic [31:0] memAddr;
      logic [31:0] memWdata;
   } dpsec_cpu_t;

   typedef struct packed {
      logic        wolProg;
      logic [31:0] wolData;
      logic        protWrite;
      logic [1:0]  protLevel;
      logic        erase;
      logic        blockGrant;
      logic [1:0]  blockKind;
   } dpsec_flash_t;

endpackage : dpsec_pkg

// ===== hdl/dpsec_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dpsec_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   // asynchronous inputs and their synchronised copy
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } dpsec_sync_st_t;

   dpsec_sync_st_t s;
   dpsec_sync_st_t next_s;

   always_comb begin
      next_s.first  = d;
      next_s.second = s.first;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.second;

endmodule : dpsec_sync

`default_nettype wire

// ===== hdl/dpsec_wol_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsec_defs.svh"

module dpsec_wol_match (
   // latch contents and majority verdict
   input  wire logic [31:0] bits,
   output logic             match
);

   logic [31:0] agree;
   logic [5:0]  count;

   // count bits equal to the key, one at 28 or more
   always_comb begin
      agree = ~(bits ^ `DPSEC_WOL_KEY);
      count = 6'h00;
      for (int i = 0; i < 32; i++) begin
         count = count + {5'h00, agree[i]};
      end
      match = (count >= `DPSEC_WOL_MIN_MATCH);
   end

endmodule : dpsec_wol_match

`default_nettype wire

// ===== hdl/dpsec_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsec_defs.svh"

module dpsec_top
   import dpsec_pkg::*;
#(
   parameter int WIN_INIT_CYCLES = `DPSEC_WIN_INIT_CYC,
   parameter int WIN_EXT_CYCLES  = `DPSEC_WIN_EXT_CYC,
   parameter logic [31:0] ACQ_KEY = `DPSEC_ACQ_KEY
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   // serial debug pins, general port pair and usb pair
   input  wire logic         portDebugClk,
   input  wire logic         portDebugData,
   input  wire logic         usbDebugClk,
   input  wire logic         usbDebugData,
   // acquisition status
   output logic              acquired,
   output logic              usbPairSelected,
   output logic              portPairSelected,
   output logic              securityLocked,
   output logic              traceLinkEnable,
   output logic              traceEvent,
   // decoded host commands and answers
   input  wire dpsec_cmd_t   cmd,
   output var  dpsec_rsp_t   rsp,
   // firmware debug enable
   input  wire logic         fwDebugEnable,
   output logic              debugEnabled,
   // processor side
   output var  dpsec_cpu_t   cpu,
   input  wire logic         memAck,
   input  wire logic [31:0]  memRdata,
   input  wire logic         fetchValid,
   input  wire logic [31:0]  fetchAddr,
   input  wire logic         litValid,
   input  wire logic [31:0]  litAddr,
   input  wire logic         dataValid,
   input  wire logic [31:0]  dataAddr,
   input  wire logic [31:0]  dataValue,
   output logic              bkptHit,
   output logic              watchEvent,
   // flash and write-once latch side
   input  wire logic [31:0]  wolBits,
   input  wire logic [1:0]   flashProtLevel,
   input  wire logic         blockAllowed,
   output var  dpsec_flash_t flash
);

   localparam int NCMP = `DPSEC_NUM_CMP;
   localparam int NPRG = `DPSEC_NUM_PROG_CMP;

   typedef struct packed {
      dpsec_acq_t                st;
      logic [`DPSEC_WIN_W-1:0]   win;
      logic [3:0]                edgesPort;
      logic [3:0]                edgesUsb;
      logic                      prevPortClk;
      logic                      prevUsbClk;
      logic                      pairUsb;
      logic                      pairSet;
      logic [31:0]               keyShift;
      logic                      locked;
      logic                      dbgEn;
      logic [NCMP-1:0]           cmpEn;
      logic [NCMP-1:0][31:0]     cmpAddr;
      dpsec_wp_t                 wpMode;
      logic [31:0]               wpLo;
      logic [31:0]               wpHi;
      logic                      memPend;
      logic                      trace;
      logic                      traceEvt;
      logic                      bkpt;
      logic                      watch;
      dpsec_rsp_t                rsp;
      dpsec_cpu_t                cpu;
      dpsec_flash_t              flash;
   } dpsec_state_t;

   dpsec_state_t s;
   dpsec_state_t next_s;

   logic [3:0]      pins;
   logic            wolMatch;
   logic [NCMP-1:0] hitVec;
   logic            wpHit;
   logic            selClk;
   logic            selData;
   logic            selRise;
   logic            portRise;
   logic            usbRise;
   logic            prog;
   logic            dbg;
   logic [31:0]     nextKey;

   dpsec_sync #(
      .WIDTH (4)
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .d       ({portDebugClk, portDebugData, usbDebugClk, usbDebugData}),
      .q       (pins)
   );

   dpsec_wol_match u_match (
      .bits  (wolBits),
      .match (wolMatch)
   );

   // comparator bank, first entries program fetch, rest literal access
   genvar g;
   generate
      for (g = 0; g < NCMP; g++) begin : g_cmp
         if (g < NPRG) begin : g_prog
            assign hitVec[g] = s.cmpEn[g] && fetchValid && (fetchAddr == s.cmpAddr[g]);
         end else begin : g_lit
            assign hitVec[g] = s.cmpEn[g] && litValid && (litAddr == s.cmpAddr[g]);
         end
      end
   endgenerate

   // watchpoint match on address, range or value
   always_comb begin
      wpHit = 1'b0;
      if (dataValid) begin
         case (s.wpMode)
            WP_ADDR:  wpHit = (dataAddr == s.wpLo);
            WP_RANGE: wpHit = (dataAddr >= s.wpLo) && (dataAddr <= s.wpHi);
            WP_VALUE: wpHit = (dataValue == s.wpHi);
            default:  wpHit = 1'b0;
         endcase
      end
   end

   assign portRise = pins[3] && !s.prevPortClk;
   assign usbRise  = pins[1] && !s.prevUsbClk;
   assign selClk   = s.pairUsb ? pins[1] : pins[3];
   assign selData  = s.pairUsb ? pins[0] : pins[2];
   assign selRise  = s.pairUsb ? usbRise : portRise;
   assign nextKey  = {s.keyShift[30:0], selData};
   assign prog     = (s.st == ST_ACQ);
   assign dbg      = prog && s.dbgEn;

   always_comb begin
      next_s = s;
      next_s.prevPortClk = pins[3];
      next_s.prevUsbClk  = pins[1];
      next_s.rsp.valid   = 1'b0;
      next_s.rsp.refused = 1'b0;
      next_s.cpu.step    = 1'b0;
      next_s.cpu.memReq  = 1'b0;
      next_s.flash.wolProg    = 1'b0;
      next_s.flash.protWrite  = 1'b0;
      next_s.flash.erase      = 1'b0;
      next_s.flash.blockGrant = 1'b0;
      if (fwDebugEnable) begin
         next_s.dbgEn = 1'b1;
      end
      case (s.st)
         ST_INIT: begin
            next_s.locked = wolMatch;
            next_s.win    = '0;
            next_s.st     = wolMatch ? ST_LOCKED : ST_OPEN;
         end
         ST_OPEN: begin
            next_s.win = s.win + 1'b1;
            if (portRise && s.edgesPort != `DPSEC_EDGE_COUNT) begin
               next_s.edgesPort = s.edgesPort + 4'h1;
            end
            if (usbRise && s.edgesUsb != `DPSEC_EDGE_COUNT) begin
               next_s.edgesUsb = s.edgesUsb + 4'h1;
            end
            if (next_s.edgesPort == `DPSEC_EDGE_COUNT) begin
               next_s.pairUsb = 1'b0;
               next_s.pairSet = 1'b1;
               next_s.win     = '0;
               next_s.st      = ST_EXT;
            end else if (next_s.edgesUsb == `DPSEC_EDGE_COUNT) begin
               next_s.pairUsb = 1'b1;
               next_s.pairSet = 1'b1;
               next_s.win     = '0;
               next_s.st      = ST_EXT;
            end else if (s.win == `DPSEC_WIN_W'(WIN_INIT_CYCLES - 1)) begin
               next_s.st = ST_CLOSED;
            end
         end
         ST_EXT: begin
            next_s.win = s.win + 1'b1;
            if (selRise) begin
               next_s.keyShift = nextKey;
            end
            if (selRise && nextKey == ACQ_KEY) begin
               next_s.st    = ST_ACQ;
               next_s.trace = 1'b1;
            end else if (s.win == `DPSEC_WIN_W'(WIN_EXT_CYCLES - 1)) begin
               next_s.st = ST_CLOSED;
            end
         end
         default: begin
         end
      endcase

      if (cmd.valid) begin
         next_s.rsp.valid   = 1'b1;
         next_s.rsp.refused = 1'b1;
         next_s.rsp.data    = 32'h0000_0000;
         case (cmd.op)
            OP_HALT: begin
               if (dbg) begin
                  next_s.cpu.halt    = 1'b1;
                  next_s.rsp.refused = 1'b0;
               end
            end
            OP_STEP: begin
               if (dbg && s.cpu.halt) begin
                  next_s.cpu.step    = 1'b1;
                  next_s.rsp.refused = 1'b0;
               end
            end
            OP_RESUME: begin
               if (dbg) begin
                  next_s.cpu.halt    = 1'b0;
                  next_s.rsp.refused = 1'b0;
               end
            end
            OP_MEM_RD, OP_MEM_WR: begin
               if (dbg && !s.memPend) begin
                  next_s.cpu.memReq   = 1'b1;
                  next_s.cpu.memWrite = (cmd.op == OP_MEM_WR);
                  next_s.cpu.memAddr  = cmd.addr;
                  next_s.cpu.memWdata = cmd.data;
                  next_s.memPend      = 1'b1;
                  next_s.rsp.valid    = 1'b0;
               end
            end
            OP_BKPT_SET: begin
               if (dbg) begin
                  next_s.cmpAddr[cmd.index] = cmd.addr;
                  next_s.cmpEn[cmd.index]   = cmd.aux[0];
                  next_s.rsp.refused        = 1'b0;
               end
            end
            OP_WP_SET: begin
               if (dbg) begin
                  next_s.wpMode      = dpsec_wp_t'(cmd.aux);
                  next_s.wpLo        = cmd.addr;
                  next_s.wpHi        = cmd.data;
                  next_s.rsp.refused = 1'b0;
               end
            end
            OP_WOL_WRITE: begin
               if (prog && flashProtLevel == `DPSEC_PROT_NONE && !wolMatch) begin
                  next_s.flash.wolProg = 1'b1;
                  next_s.flash.wolData = cmd.data;
                  next_s.rsp.refused   = 1'b0;
               end
            end
            OP_WOL_READ: begin
               if (prog) begin
                  next_s.rsp.data    = wolBits;
                  next_s.rsp.refused = 1'b0;
               end
            end
            OP_PROT_RAISE: begin
               if (prog && cmd.aux > flashProtLevel) begin
                  next_s.flash.protWrite = 1'b1;
                  next_s.flash.protLevel = cmd.aux;
                  next_s.rsp.refused     = 1'b0;
               end
            end
            OP_FULL_ERASE: begin
               if (prog) begin
                  next_s.flash.erase     = 1'b1;
                  next_s.flash.protWrite = 1'b1;
                  next_s.flash.protLevel = `DPSEC_PROT_NONE;
                  next_s.rsp.refused     = 1'b0;
               end
            end
            OP_BLOCK_OP: begin
               if (prog && blockAllowed) begin
                  next_s.flash.blockGrant = 1'b1;
                  next_s.flash.blockKind  = cmd.aux;
                  next_s.rsp.refused      = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      if (s.memPend && memAck) begin
         next_s.memPend     = 1'b0;
         next_s.rsp.valid   = 1'b1;
         next_s.rsp.refused = 1'b0;
         next_s.rsp.data    = memRdata;
      end

      next_s.bkpt     = dbg && (|hitVec);
      next_s.watch    = dbg && wpHit;
      next_s.traceEvt = s.trace && s.dbgEn && wpHit;
      if (dbg && (|hitVec)) begin
         next_s.cpu.halt = 1'b1;
      end
      if (s.locked) begin
         next_s.cpu   = '0;
         next_s.flash = '0;
         next_s.trace = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign acquired         = (s.st == ST_ACQ);
   assign usbPairSelected  = s.pairSet && s.pairUsb;
   assign portPairSelected = s.pairSet && !s.pairUsb;
   assign securityLocked   = s.locked;
   assign traceLinkEnable  = s.trace;
   assign traceEvent       = s.traceEvt;
   assign rsp              = s.rsp;
   assign debugEnabled     = s.dbgEn;
   assign cpu              = s.cpu;
   assign bkptHit          = s.bkpt;
   assign watchEvent       = s.watch;
   assign flash            = s.flash;

endmodule : dpsec_top

`default_nettype wire

// ===== verif/dpsec_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dpsec_host_model #(
   parameter int HALF_NS = 80
) (
   // general port pair
   output logic portDebugClk,
   output logic portDebugData,
   // usb pair
   output logic usbDebugClk,
   output logic usbDebugData
);
   logic clk;
   logic dat;
   logic useUsb;

   // only the chosen pair carries the frame, the other stays low
   assign portDebugClk  = !useUsb && clk;
   assign usbDebugClk   = useUsb && clk;
   assign portDebugData = useUsb ? 1'b0 : dat;
   assign usbDebugData  = useUsb ? dat : 1'b0;

   initial begin
      clk    = 1'b0;
      dat    = 1'b0;
      useUsb = 1'b0;
   end

   // bit set up while the clock is low, taken on its rising edge
   task automatic tick(input logic b);
      dat = b;
      #(HALF_NS);
      clk = 1'b1;
      #(HALF_NS);
      clk = 1'b0;
   endtask : tick

   // eight clocks, a pause, then the key msb first; clock stands still between
   task automatic acquire(input logic usb, input logic [31:0] key, input int gapNs);
      useUsb = usb;
      for (int i = 0; i < 8; i++) tick(~dat);
      dat = ~dat;
      #(gapNs);
      for (int i = 31; i >= 0; i--) tick(key[i]);
      dat = ~dat;
   endtask : acquire
endmodule : dpsec_host_model

`default_nettype wire

// ===== verif/dpsec_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module dpsec_top_chk
   import dpsec_pkg::*;
#(
   parameter int WIN_INIT_CYCLES = 80,
   parameter int WIN_EXT_CYCLES  = 400
) (
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         resetn,
   // status
   input wire logic         acquired,
   input wire logic         usbPairSelected,
   input wire logic         portPairSelected,
   input wire logic         securityLocked,
   input wire logic         traceLinkEnable,
   input wire logic         fwDebugEnable,
   input wire logic         debugEnabled,
   // commands, latch and flash
   input wire dpsec_cmd_t   cmd,
   input wire dpsec_rsp_t   rsp,
   input wire logic         memAck,
   input wire logic [31:0]  wolBits,
   input wire logic [1:0]   flashProtLevel,
   input wire logic         blockAllowed,
   input wire dpsec_flash_t flash
);
   logic [31:0] sinceReset;

   always_ff @(posedge ref_clk) sinceReset <= resetn ? sinceReset + 32'h1 : 32'h0;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_window;
      $rose(acquired) |-> sinceReset <= WIN_INIT_CYCLES + WIN_EXT_CYCLES + 8;
   endproperty
   a_window: assert property (p_window) else $error("acquired after window");
   property p_one_pair; !(usbPairSelected && portPairSelected); endproperty
   a_one_pair: assert property (p_one_pair) else $error("both pairs selected");
   property p_trace; acquired |-> traceLinkEnable; endproperty
   a_trace: assert property (p_trace) else $error("trace link off");
   property p_dbg_fw; $rose(debugEnabled) |-> $past(fwDebugEnable); endproperty
   a_dbg_fw: assert property (p_dbg_fw) else $error("debug enabled by itself");
   property p_lock; securityLocked |-> !acquired && !traceLinkEnable; endproperty
   a_lock: assert property (p_lock) else $error("access while locked");
   property p_lock_hold; securityLocked |=> securityLocked; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
   property p_wol_prot;
      cmd.valid && cmd.op == OP_WOL_WRITE && flashProtLevel != 2'h0 |=> !flash.wolProg;
   endproperty
   a_wol_prot: assert property (p_wol_prot) else $error("latch written");
   property p_prot;
      cmd.valid && cmd.op == OP_PROT_RAISE && cmd.aux <= flashProtLevel |=> !flash.protWrite;
   endproperty
   a_prot: assert property (p_prot) else $error("protection lowered");
   property p_block;
      cmd.valid && cmd.op == OP_BLOCK_OP && !blockAllowed |=> !flash.blockGrant;
   endproperty
   a_block: assert property (p_block) else $error("block op granted");
   property p_wol_read;
      cmd.valid && cmd.op == OP_WOL_READ && acquired && !memAck
         |=> rsp.valid && !rsp.refused && rsp.data == $past(wolBits);
   endproperty
   a_wol_read: assert property (p_wol_read) else $error("latch read wrong");
   property p_unacq; cmd.valid && !acquired && !memAck |=> rsp.valid && rsp.refused; endproperty
   a_unacq: assert property (p_unacq) else $error("command taken unacquired");
endmodule : dpsec_top_chk

bind dpsec_top dpsec_top_chk #(
   .WIN_INIT_CYCLES(WIN_INIT_CYCLES),
   .WIN_EXT_CYCLES(WIN_EXT_CYCLES)
) u_chk (.ref_clk, .resetn, .acquired, .usbPairSelected, .portPairSelected, .securityLocked,
   .traceLinkEnable, .fwDebugEnable, .debugEnabled, .cmd, .rsp, .memAck, .wolBits,
   .flashProtLevel, .blockAllowed, .flash);

`default_nettype wire

// ===== verif/dpsec_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsec_defs.svh"

module dpsec_top_bench;
   import dpsec_pkg::*;
   localparam int          WIN_INIT = 200;
   localparam int          WIN_EXT  = 800;
   localparam logic [31:0] ACQ      = 32'h1e2d3c4b; // arbitrary acquire key
   localparam logic [31:0] BLANK    = 32'h0f0f0f0f;
   localparam logic [31:0] LOCK     = `DPSEC_WOL_KEY;
   logic         ref_clk, resetn, fwDebugEnable, memAck, fetchValid, litValid;
   logic         dataValid, blockAllowed, acquired, usbPairSelected, portPairSelected;
   logic         portDebugClk, portDebugData, usbDebugClk, usbDebugData, securityLocked;
   logic         traceLinkEnable, traceEvent, debugEnabled, bkptHit, watchEvent;
   logic [31:0]  memRdata, fetchAddr, litAddr, dataAddr, dataValue, wolBits;
   logic [1:0]   flashProtLevel;
   dpsec_cmd_t   cmd;
   dpsec_rsp_t   rsp, r;
   dpsec_cpu_t   cpu;
   dpsec_flash_t flash, f;
   int           n_fail = 0;
   int           n_compared = 0;

   dpsec_host_model host (.portDebugClk, .portDebugData, .usbDebugClk, .usbDebugData);
   dpsec_top #(.WIN_INIT_CYCLES(WIN_INIT), .WIN_EXT_CYCLES(WIN_EXT), .ACQ_KEY(ACQ)) dut (
      .ref_clk, .resetn, .portDebugClk, .portDebugData, .usbDebugClk, .usbDebugData,
      .acquired, .usbPairSelected, .portPairSelected, .securityLocked, .traceLinkEnable,
      .traceEvent, .cmd, .rsp, .fwDebugEnable, .debugEnabled, .cpu, .memAck, .memRdata,
      .fetchValid, .fetchAddr, .litValid, .litAddr, .dataValid, .dataAddr, .dataValue,
      .bkptHit, .watchEvent, .wolBits, .flashProtLevel, .blockAllowed, .flash);

   always #5 ref_clk = ~ref_clk;

   // processor stub answers each memory request one cycle later
   always @(posedge ref_clk) begin
      memAck   <= cpu.memReq;
      memRdata <= ~cpu.memAddr;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic do_reset();
      @(posedge ref_clk) resetn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : do_reset

   task automatic send(input dpsec_op_t op, input logic [2:0] idx = 3'h0,
                       input logic [1:0] aux = 2'h0, input logic [31:0] a = 32'h0,
                       input logic [31:0] d = 32'h0);
      int n;
      @(posedge ref_clk) cmd <= '{1'b1, op, idx, aux, a, d};
      @(posedge ref_clk) cmd.valid <= 1'b0;
      #1;
      for (n = 0; n < 8 && rsp.valid !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      r = rsp;
      f = flash;
      if (n == 8) begin
         n_fail++;
         conclude();
      end
   endtask : send

   task automatic await_acq();
      for (int n = 0; n < 12 && acquired !== 1'b1; n++) @(posedge ref_clk);
      #1;
   endtask : await_acq

   // one access on fetch (0), literal (1) or data (2) bus
   task automatic strobe(input int bus, input logic [31:0] a, input logic [31:0] v);
      @(posedge ref_clk) begin
         fetchValid <= (bus == 0);
         litValid   <= (bus == 1);
         dataValid  <= (bus == 2);
         {fetchAddr, litAddr, dataAddr, dataValue} <= {a, a, a, v};
      end
      @(posedge ref_clk) {fetchValid, litValid, dataValid} <= 3'h0;
      #1;
   endtask : strobe

   task automatic s_expire();
      do_reset();
      repeat (WIN_INIT + 20) @(posedge ref_clk);
      host.acquire(1'b0, ACQ, 0);
      await_acq();
      check(acquired, 1'b0);
      check(portPairSelected, 1'b0);
      send(OP_WOL_READ);
      check(r.refused, 1'b1);
   endtask : s_expire

   task automatic s_port();
      do_reset();
      host.acquire(1'b0, ACQ, 1000);
      await_acq();
      check(acquired, 1'b1);
      check({usbPairSelected, portPairSelected, traceLinkEnable, debugEnabled}, 4'h6);
      send(OP_HALT);
      check(r.refused, 1'b1);
      @(posedge ref_clk) fwDebugEnable <= 1'b1;
      send(OP_HALT);
      check({r.refused, cpu.halt}, 2'h1);
      send(OP_MEM_RD, 3'h0, 2'h0, 32'h20000010);
      check({r.refused, r.data}, {1'b0, ~32'h20000010});
      send(OP_WOL_READ);
      check(r.data, BLANK);
      @(posedge ref_clk) flashProtLevel <= 2'h1;
      send(OP_WOL_WRITE, 3'h0, 2'h0, 32'h0, LOCK);
      check({r.refused, f.wolProg}, 2'h2);
      send(OP_PROT_RAISE, 3'h0, 2'h1);
      check({r.refused, f.protWrite}, 2'h2);
      send(OP_PROT_RAISE, 3'h0, 2'h2);
      check({r.refused, f.protWrite, f.protLevel}, 4'h6);
      send(OP_FULL_ERASE);
      check({f.erase, f.protWrite, f.protLevel}, 4'hc);
      @(posedge ref_clk) flashProtLevel <= 2'h0;
      send(OP_WOL_WRITE, 3'h0, 2'h0, 32'h0, LOCK);
      check({r.refused, f.wolProg, f.wolData}, {2'h1, LOCK});
      send(OP_BLOCK_OP);
      check({r.refused, f.blockGrant}, 2'h2);
      @(posedge ref_clk) blockAllowed <= 1'b1;
      send(OP_BLOCK_OP);
      check({r.refused, f.blockGrant}, 2'h1);
      @(posedge ref_clk) wolBits <= LOCK;
      repeat (4) @(posedge ref_clk);
      check({acquired, securityLocked}, 2'h2);
      strobe(0, 32'h9000, 32'h0);
      check(bkptHit, 1'b0);
      for (int i = 0; i < 8; i++) begin
         send(OP_BKPT_SET, 3'(i), 2'h1, 32'h1000 + 32'(i) * 32'h10);
         strobe(i < 6 ? 0 : 1, 32'h1000 + 32'(i) * 32'h10, 32'h0);
         check(bkptHit, 1'b1);
      end
      for (int m = 1; m < 4; m++) begin
         send(OP_WP_SET, 3'h0, 2'(m), 32'h2100, 32'h2110);
         strobe(2, 32'h2400, 32'h0);
         check(watchEvent, 1'b0);
         strobe(2, m == 1 ? 32'h2100 : (m == 2 ? 32'h2108 : 32'h2400), 32'h2110);
         check({watchEvent, traceEvent}, 2'h3);
      end
   endtask : s_port

   task automatic s_usb();
      @(posedge ref_clk) wolBits <= BLANK;
      do_reset();
      host.acquire(1'b1, ACQ, 0);
      await_acq();
      check(acquired, 1'b1);
      check({usbPairSelected, portPairSelected}, 2'h2);
   endtask : s_usb

   task automatic s_lock();
      @(posedge ref_clk) wolBits <= LOCK ^ 32'h0000000f;
      do_reset();
      check(securityLocked, 1'b1);
      host.acquire(1'b0, ACQ, 0);
      await_acq();
      check({acquired, traceLinkEnable, portPairSelected}, 3'h0);
      send(OP_WOL_WRITE, 3'h0, 2'h0, 32'h0, BLANK);
      check({r.refused, f.wolProg}, 2'h2);
      @(posedge ref_clk) wolBits <= LOCK ^ 32'h0000001f;
      do_reset();
      check(securityLocked, 1'b0);
   endtask : s_lock

   initial begin
      ref_clk = 1'b0;
      {resetn, fwDebugEnable, fetchValid, litValid, dataValid, blockAllowed} = '0;
      {fetchAddr, litAddr, dataAddr, dataValue} = '0;
      flashProtLevel = 2'h0;
      wolBits = BLANK;
      cmd = '0;
      s_expire();
      s_port();
      s_usb();
      s_lock();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end
endmodule : dpsec_top_bench

`default_nettype wire
